/* afs_hold_if.sv */
// Purpose: link between supervisor and hold-current timer
// Assumes: one clock
// Notes: none
`timescale 1ns/1ps
interface afs_hold_if;
   logic sample_tick;
   logic at_rest;
   logic [14:0] mode;
   logic low_current;
   modport sup (output sample_tick, output at_rest, output mode, input low_current);
   modport tmr (input sample_tick, input at_rest, input mode, output low_current);
endinterface : afs_hold_if

/* afs_hold_timer.sv */
// Purpose: hold-current reduction timer
// Assumes: sample_tick one pulse per servo sample
// Notes: counts samples after the move ends
`timescale 1ns/1ps
module afs_hold_timer (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // supervisor side
   afs_hold_if.tmr h
);
   logic [14:0] cnt_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 15'h0000;
      end else if (!h.at_rest) begin
         cnt_q <= 15'h0000;
      end else if (h.sample_tick && cnt_q != 15'h7FFF) begin
         cnt_q <= cnt_q + 15'd1;
      end
   end
   // mode 0 full, 1 immediate, 2.. delayed
   always_comb begin
      if (h.mode == 15'd0) begin
         h.low_current = 1'b0; // [RULE19]
      end else if (h.mode == 15'd1) begin
         h.low_current = h.at_rest; // [RULE19]
      end else begin
         h.low_current = h.at_rest && (cnt_q >= h.mode); // [RULE19]
      end
   end
endmodule : afs_hold_timer

/* afs_pkg.sv */
// Purpose: shared constants for the amplifier fault supervisor
// Assumes: 32-bit apb, pclk at 20 MHz
// Notes: all offsets are byte addresses
package afs_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CMD = 8'h04;
   localparam logic [7:0] ADDR_QUERY = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_STEP = 8'h10;
   localparam logic [7:0] ADDR_HOLD = 8'h14;
   localparam logic [7:0] ADDR_LIMIT = 8'h18;
   // thresholds in sensor units (volts, amps, deg c)
   localparam logic [7:0] UV_VOLTS = 8'd18;
   localparam logic [7:0] OV_TRIP_VOLTS = 8'd94;
   localparam logic [7:0] OV_CLEAR_VOLTS = 8'd90;
   localparam logic [7:0] OC_PAIR_AMPS = 8'd20;
   localparam logic [7:0] OT_DEG_C = 8'd80;
   // status bit positions, selector 0
   localparam int ST_UV = 0;
   localparam int ST_OV = 1;
   localparam int ST_OC = 2;
   localparam int ST_OT = 3;
   // query selectors and lockout answer
   localparam logic [1:0] SEL_FAULTS = 2'd0;
   localparam logic [1:0] SEL_CONT = 2'd2;
   localparam logic [1:0] SEL_LOCK = 2'd3;
   localparam logic [7:0] LOCK_ANSWER = 8'h03;
   // command bits
   localparam int CMD_ENABLE = 0;
   localparam int CMD_MOTOR_OFF = 1;
   localparam int CMD_RESET = 2;
   // reset values
   localparam logic [2:0] RST_MTYPE = 3'd0;
   localparam logic [7:0] RST_GAIN = 8'h00;
   localparam logic [4:0] RST_RES = 5'd1;
   localparam logic [14:0] RST_HOLD = 15'h0000;
   localparam logic [7:0] RST_CONT_LIM = 8'd10;
   // hold current in percent
   localparam logic [6:0] PCT_FULL = 7'd100;
   localparam logic [6:0] PCT_LOW = 7'd25;
   localparam logic [6:0] PCT_FULLSTEP = 7'd70;
   // servo sample period
   localparam int SAMPLE_US = 1000;
   localparam int CLK_MHZ = 20;
   localparam int SAMPLE_CYC = SAMPLE_US * CLK_MHZ;
   // motor type encodings: 0, 1, 2 stand for types -2, -2.5, 1
   typedef enum logic [2:0] {
      AFS_MT_STEP = 3'd0,
      AFS_MT_STEP_HALF = 3'd1,
      AFS_MT_SERVO = 3'd2
   } afs_mtype_t;
endpackage : afs_pkg

/* afs_sensor_model.sv */
// Purpose: plant model, power stage sensors, lockout pin and axis state
// Assumes: bench sets the requested plant state
// Notes: readings move on the rising edge, like a converter latch
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
module afs_sensor_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // requested plant state
   input wire logic [7:0] volts_req,
   input wire logic [7:0] amps_req,
   input wire logic [7:0] deg_req,
   input wire logic lock_req,
   input wire logic short_req,
   input wire logic rest_req,
   // sensed values
   output logic [7:0] supply_volts,
   output logic [7:0] pair_amps,
   output logic [7:0] sink_deg_c,
   output logic lockout_input,
   output logic drive_short,
   output logic move_done
);
   // front end reads zero until released
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         supply_volts <= 8'h00;
         pair_amps <= 8'h00;
         sink_deg_c <= 8'h00;
         lockout_input <= 1'b0;
         drive_short <= 1'b0;
         move_done <= 1'b0;
      end else begin
         supply_volts <= volts_req;
         pair_amps <= amps_req;
         sink_deg_c <= deg_req;
         lockout_input <= lock_req;
         drive_short <= short_req;
         move_done <= rest_req;
      end
   end
endmodule : afs_sensor_model

/* afs_supervisor.sv */
// Purpose: amplifier fault supervisor with apb registers
// Assumes: sensor values are already digitised, asynchronous to pclk
// Notes: sensor and program-state pins other than amp_fault_handler_label pass two flip-flops before use; apb pins do not
//
// Summary of operation
// [RULE1] query selector 0,2,3 returns eight-bit status
// [RULE2] selector 0 flags uv, ov, oc, ot
// [RULE3] selector 2 flags continuous current exceeded
// [RULE4] selector 3 reports lockout triggered
// [RULE5] faults vector thread zero to handler
// [RULE6] disable below 18 volts, self-clearing
// [RULE7] power-up undervoltage triggers handler
// [RULE8] over 94 off, below 90 on
// [RULE9] overvoltage self-clears, no handler
// [RULE10] pair current over 20 latches off
// [RULE11] overcurrent shutdown is unconditional
// [RULE12] over 80 degrees off plus handler
// [RULE13] overtemp clears by cool then enable
// [RULE14] lockout kills stage, motor off, answers 3
// [RULE15] host recovers lockout: off then enable
// [RULE16] host should set off-on-error with lockout
// [RULE17] motor type defaults stepper, servo selectable
// [RULE18] stepper current 0.5 to 1.4 amps
// [RULE19] hold mode 0 full, 1 low, delayed
// [RULE20] resolution codes 1, 2, 4, 16
// [RULE21] drive short sets bit 0, disables
// [RULE22] host clears drive error: off, hold 0, enable
// [RULE23] compare each sample, latch until recovery
`timescale 1ns/1ps
module afs_supervisor #(
   parameter int SAMPLE_CYCLES = afs_pkg::SAMPLE_CYC
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // sensors, asynchronous
   input wire logic [7:0] supply_volts,
   input wire logic [7:0] pair_amps,
   input wire logic [7:0] sink_deg_c,
   input wire logic lockout_input,
   input wire logic drive_short,
   // program state
   input wire logic thread0_running,
   input wire logic amp_fault_handler_label,
   input wire logic move_done,
   // outputs
   output logic amp_enable,
   output logic motor_off,
   output logic handler_jump,
   output logic [6:0] hold_pct,
   output logic step_active_high
);
   ////////////////////////////////////////////////////////////////////
   // input synchronisers
   localparam int SW = 8 * 3 + 4;
   logic [SW-1:0] s1_q, s2_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= {supply_volts, pair_amps, sink_deg_c, lockout_input, drive_short,
                  thread0_running, move_done};
         s2_q <= s1_q;
      end
   end
   logic [7:0] volts, amps, degc;
   logic lock_in, short_in, thr0, moving_done;
   assign {volts, amps, degc, lock_in, short_in, thr0, moving_done} = s2_q;

   ////////////////////////////////////////////////////////////////////
   // sample tick
   logic [$clog2(SAMPLE_CYCLES)-1:0] tick_cnt_q;
   logic tick;
   assign tick = (tick_cnt_q == '0);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_q <= '0;
      end else if (tick) begin
         tick_cnt_q <= ($clog2(SAMPLE_CYCLES))'(SAMPLE_CYCLES - 1); // [RULE23]
      end else begin
         tick_cnt_q <= tick_cnt_q - 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // apb access and command pulses
   logic wr, rd;
   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;
   assign pready = 1'b1;
   function automatic logic mapped(input logic [7:0] a);
      return a == afs_pkg::ADDR_CTRL || a == afs_pkg::ADDR_CMD ||
             a == afs_pkg::ADDR_QUERY || a == afs_pkg::ADDR_STATUS ||
             a == afs_pkg::ADDR_STEP || a == afs_pkg::ADDR_HOLD ||
             a == afs_pkg::ADDR_LIMIT;
   endfunction : mapped
   assign pslverr = psel && penable && !mapped(paddr);
   logic cmd_wr, en_cmd, off_cmd, rst_cmd;
   assign cmd_wr = wr && paddr == afs_pkg::ADDR_CMD;
   assign en_cmd = cmd_wr && pwdata[afs_pkg::CMD_ENABLE];
   assign off_cmd = cmd_wr && pwdata[afs_pkg::CMD_MOTOR_OFF];
   assign rst_cmd = cmd_wr && pwdata[afs_pkg::CMD_RESET];

   ////////////////////////////////////////////////////////////////////
   // configuration registers
   afs_pkg::afs_mtype_t mtype_q;
   logic [7:0] gain_q, cont_lim_q;
   logic [4:0] res_q;
   logic [14:0] hold_q;
   logic [1:0] sel_q;
   function automatic logic res_ok(input logic [4:0] c);
      return c == 5'd1 || c == 5'd2 || c == 5'd4 || c == 5'd16; // [RULE20]
   endfunction : res_ok
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mtype_q <= afs_pkg::AFS_MT_STEP; // [RULE17]
         gain_q <= afs_pkg::RST_GAIN;
         res_q <= afs_pkg::RST_RES;
         hold_q <= afs_pkg::RST_HOLD;
         cont_lim_q <= afs_pkg::RST_CONT_LIM;
         sel_q <= afs_pkg::SEL_FAULTS;
      end else if (rst_cmd) begin
         mtype_q <= afs_pkg::AFS_MT_STEP;
         res_q <= afs_pkg::RST_RES;
         hold_q <= afs_pkg::RST_HOLD;
      end else if (wr) begin
         unique case (paddr)
            afs_pkg::ADDR_CTRL: begin
               if (pwdata[1:0] != 2'd3) begin
                  mtype_q <= afs_pkg::afs_mtype_t'({1'b0, pwdata[1:0]}); // [RULE17]
               end
            end
            afs_pkg::ADDR_QUERY: begin
               if (pwdata[1:0] != 2'd1) begin
                  sel_q <= pwdata[1:0]; // [RULE1]
               end
            end
            afs_pkg::ADDR_STEP: begin
               gain_q <= pwdata[7:0]; // [RULE18]
               if (res_ok(pwdata[12:8])) begin
                  res_q <= pwdata[12:8]; // [RULE20]
               end
            end
            afs_pkg::ADDR_HOLD: hold_q <= pwdata[14:0]; // [RULE19]
            afs_pkg::ADDR_LIMIT: cont_lim_q <= pwdata[7:0];
            default: ;
         endcase
      end
   end
   // gain 0..128 maps 0.5 A + n * 7 mA up to 1.4 A
   logic [7:0] gain_eff;
   assign gain_eff = (gain_q > 8'd128) ? 8'd128 : gain_q; // [RULE18]

   ////////////////////////////////////////////////////////////////////
   // protection comparisons, evaluated every sample
   logic uv_q, ov_q, oc_q, ot_q, cont_q, lock_q, short_q;
   logic oc_now, ot_now;
   assign oc_now = amps > afs_pkg::OC_PAIR_AMPS;
   assign ot_now = degc > afs_pkg::OT_DEG_C;
   logic clear_req;
   assign clear_req = en_cmd || rst_cmd;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         uv_q <= 1'b0;
         ov_q <= 1'b0;
         cont_q <= 1'b0;
      end else if (tick) begin
         uv_q <= volts < afs_pkg::UV_VOLTS; // [RULE6]
         if (volts > afs_pkg::OV_TRIP_VOLTS) begin
            ov_q <= 1'b1; // [RULE8]
         end else if (volts < afs_pkg::OV_CLEAR_VOLTS) begin
            ov_q <= 1'b0; // [RULE9]
         end
         cont_q <= amps > cont_lim_q; // [RULE3]
      end
   end
   // latched faults; a live condition wins over a clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oc_q <= 1'b0;
         ot_q <= 1'b0;
      end else begin
         if (tick && oc_now) begin
            oc_q <= 1'b1; // [RULE10] [RULE11]
         end else if (clear_req && !oc_now) begin
            oc_q <= 1'b0; // [RULE10]
         end
         if (tick && ot_now) begin
            ot_q <= 1'b1; // [RULE12]
         end else if (clear_req && !ot_now) begin
            ot_q <= 1'b0; // [RULE13]
         end
      end
   end
   // lockout: off then enable, or reset; drive short also needs hold 0 before the enable
   logic off_seen_q;
   logic lock_clr;
   assign lock_clr = rst_cmd || (en_cmd && off_seen_q);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_q <= 1'b0;
         short_q <= 1'b0;
         off_seen_q <= 1'b0;
      end else begin
         if (off_cmd) begin
            off_seen_q <= 1'b1;
         end else if (en_cmd) begin
            off_seen_q <= 1'b0;
         end
         if (lock_in) begin
            lock_q <= 1'b1; // [RULE14]
         end else if (lock_clr) begin
            lock_q <= 1'b0; // [RULE15]
         end
         if (short_in) begin
            short_q <= 1'b1; // [RULE21]
         end else if (rst_cmd || (en_cmd && off_seen_q && hold_q == 15'd0)) begin
            short_q <= 1'b0; // [RULE22]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // handler vectoring on a new handler-worthy fault
   logic hfault, hfault_prev_q;
   assign hfault = uv_q || oc_q || ot_q || lock_q || short_q; // [RULE9]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hfault_prev_q <= 1'b0; // undervoltage at power-up is a new fault
         handler_jump <= 1'b0;
      end else begin
         // a fault raised before the program runs stays new until vectored
         hfault_prev_q <= hfault && thr0 && amp_fault_handler_label;
         handler_jump <= hfault && !hfault_prev_q && thr0 &&
                         amp_fault_handler_label; // [RULE5] [RULE7] [RULE12]
      end
   end

   ////////////////////////////////////////////////////////////////////
   // power stage and motor state
   logic motor_off_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         motor_off_q <= 1'b1;
      end else if (lock_in || (lock_q && !lock_clr)) begin
         motor_off_q <= 1'b1; // [RULE14]
      end else if (off_cmd) begin
         motor_off_q <= 1'b1;
      end else if (en_cmd) begin
         motor_off_q <= 1'b0;
      end
   end
   assign motor_off = motor_off_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         amp_enable <= 1'b0;
      end else begin
         amp_enable <= !(motor_off_q || uv_q || ov_q || oc_q || ot_q || lock_q ||
                         short_q || lock_in); // [RULE6] [RULE8] [RULE11] [RULE14] [RULE21]
      end
   end

   ////////////////////////////////////////////////////////////////////
   // hold current
   afs_hold_if hif ();
   assign hif.sample_tick = tick;
   assign hif.at_rest = moving_done;
   assign hif.mode = hold_q;
   afs_hold_timer u_hold (
      .pclk(pclk),
      .presetn(presetn),
      .h(hif)
   );
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_pct <= afs_pkg::PCT_FULL;
         step_active_high <= 1'b1;
      end else begin
         step_active_high <= mtype_q != afs_pkg::AFS_MT_SERVO; // [RULE17]
         if (hif.low_current) begin
            hold_pct <= afs_pkg::PCT_LOW; // [RULE19]
         end else if (res_q == 5'd1 && moving_done) begin
            hold_pct <= afs_pkg::PCT_FULLSTEP; // [RULE20]
         end else begin
            hold_pct <= afs_pkg::PCT_FULL;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // status query and read data
   logic [7:0] query_val;
   always_comb begin
      unique case (sel_q)
         afs_pkg::SEL_FAULTS: begin
            query_val = 8'h00;
            query_val[afs_pkg::ST_UV] = uv_q || short_q; // [RULE2] [RULE21]
            query_val[afs_pkg::ST_OV] = ov_q; // [RULE2]
            query_val[afs_pkg::ST_OC] = oc_q; // [RULE2]
            query_val[afs_pkg::ST_OT] = ot_q; // [RULE2]
         end
         afs_pkg::SEL_CONT: query_val = {7'd0, cont_q}; // [RULE3]
         afs_pkg::SEL_LOCK: query_val = lock_q ? afs_pkg::LOCK_ANSWER : 8'h00; // [RULE4]
         default: query_val = 8'h00;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         unique case (paddr)
            afs_pkg::ADDR_CTRL: prdata <= {29'd0, mtype_q};
            afs_pkg::ADDR_QUERY: prdata <= {30'd0, sel_q};
            afs_pkg::ADDR_STATUS: prdata <= {24'd0, query_val}; // [RULE1]
            afs_pkg::ADDR_STEP: prdata <= {19'd0, res_q, gain_eff};
            afs_pkg::ADDR_HOLD: prdata <= {17'd0, hold_q};
            afs_pkg::ADDR_LIMIT: prdata <= {24'd0, cont_lim_q};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   a_ot_disables: assert property (@(posedge pclk) disable iff (!presetn)
      ot_q |=> !amp_enable) else $error("overtemp left amp on"); // [RULE12]
   a_oc_latches: assert property (@(posedge pclk) disable iff (!presetn)
      oc_q && !clear_req |=> oc_q) else $error("overcurrent cleared early"); // [RULE10]
   a_lock_answer: assert property (@(posedge pclk) disable iff (!presetn)
      lock_q && sel_q == afs_pkg::SEL_LOCK |-> query_val == 8'h03)
      else $error("lockout answer wrong"); // [RULE14]
   a_lock_motor_off: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(lock_q) |=> motor_off) else $error("lockout kept motor on"); // [RULE14]
   a_ov_no_handler: assert property (@(posedge pclk) disable iff (!presetn)
      ov_q && !uv_q && !oc_q && !ot_q && !lock_q && !short_q |=> !handler_jump)
      else $error("handler on overvoltage"); // [RULE9]
   a_uv_clears: assert property (@(posedge pclk) disable iff (!presetn)
      tick && volts >= afs_pkg::UV_VOLTS |=> !uv_q) else $error("uv stuck"); // [RULE6]
   a_short_bit0: assert property (@(posedge pclk) disable iff (!presetn)
      short_q && sel_q == afs_pkg::SEL_FAULTS |-> query_val[0])
      else $error("short not on bit 0"); // [RULE21]
   a_ov_hyst: assert property (@(posedge pclk) disable iff (!presetn)
      tick && volts > afs_pkg::OV_TRIP_VOLTS |=> ov_q ##1 !amp_enable)
      else $error("ov did not trip"); // [RULE8]
   c_handler: cover property (@(posedge pclk) handler_jump);
   c_lock_recover: cover property (@(posedge pclk) $fell(lock_q));
   c_low_current: cover property (@(posedge pclk) hold_pct == afs_pkg::PCT_LOW);
endmodule : afs_supervisor

/* afs_supervisor_bench.sv */
// Purpose: self-checking bench for the amplifier fault supervisor
// Assumes: sample period shortened to 8 clocks
// Notes: plant driven through the sensor model
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
module afs_supervisor_bench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr, volts_req, amps_req, deg_req, supply_volts, pair_amps, sink_deg_c;
   logic [31:0] pwdata, prdata, rd;
   logic amp_enable, motor_off, handler_jump, step_active_high;
   logic [6:0] hold_pct;
   logic lock_req, short_req, rest_req, lockout_input, drive_short, move_done;
   logic thread0_running, amp_fault_handler_label;
   int failures, tests_run, jumps, j0;
   int res_codes[4] = '{1, 2, 4, 16};
   localparam int SAMP = 8;
   afs_supervisor #(.SAMPLE_CYCLES(SAMP)) afs_supervisor_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .supply_volts(supply_volts),
      .pair_amps(pair_amps), .sink_deg_c(sink_deg_c), .lockout_input(lockout_input),
      .drive_short(drive_short), .thread0_running(thread0_running),
      .amp_fault_handler_label(amp_fault_handler_label), .move_done(move_done),
      .amp_enable(amp_enable), .motor_off(motor_off), .handler_jump(handler_jump),
      .hold_pct(hold_pct), .step_active_high(step_active_high));
   afs_sensor_model afs_sensor_model_inst (.pclk(pclk), .presetn(presetn),
      .volts_req(volts_req), .amps_req(amps_req), .deg_req(deg_req), .lock_req(lock_req),
      .short_req(short_req), .rest_req(rest_req), .supply_volts(supply_volts),
      .pair_amps(pair_amps), .sink_deg_c(sink_deg_c), .lockout_input(lockout_input),
      .drive_short(drive_short), .move_done(move_done));
   ////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (handler_jump === 1'b1) jumps++;
   end
   ////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) chk("pready", 1, pready);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(what, exp, rd);
   endtask : rchk
   task automatic q(input logic [1:0] sel, input logic [31:0] exp);
      wr(afs_pkg::ADDR_QUERY, {30'h0000_0000, sel});
      rchk("status", afs_pkg::ADDR_STATUS, exp);
   endtask : q
   task automatic cmd(input int b);
      wr(afs_pkg::ADDR_CMD, 32'h0000_0001 << b);
   endtask : cmd
   task automatic settle;
      repeat (4 * SAMP + 8) @(posedge pclk);
   endtask : settle
   task automatic en_chk(input string what, input logic exp);
      int n;
      n = 0;
      while (amp_enable !== exp && n < 64) begin
         @(posedge pclk);
         n++;
      end
      chk(what, exp, amp_enable);
   endtask : en_chk
   task automatic jchk(input int more);
      chk("handler pulses", j0 + more, jumps);
      j0 = jumps;
   endtask : jchk
   task print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : print_verdict
   ////////////////////////////////////////////////////////////////
   initial begin
      #(50 * 20000);
      failures++;
      $display("BAD watchdog expected finish seen hang");
      print_verdict;
   end
   initial begin
      {presetn, psel, penable, pwrite, lock_req, short_req, rest_req} = '0;
      {paddr, volts_req, amps_req, deg_req} = '0;
      pwdata = '0;
      {thread0_running, amp_fault_handler_label} = 2'b11;
      {failures, tests_run, jumps, j0} = '0;
      repeat (5) @(posedge pclk);
      chk("amp_enable in reset", 0, amp_enable);
      chk("motor_off in reset", 1, motor_off);
      chk("step_active_high in reset", 1, step_active_high);
      presetn <= 1'b1;
      rchk("ctrl", afs_pkg::ADDR_CTRL, 32'h0000_0000);
      rchk("step", afs_pkg::ADDR_STEP, 32'h0000_0100);
      rchk("hold", afs_pkg::ADDR_HOLD, 32'h0000_0000);
      rchk("limit", afs_pkg::ADDR_LIMIT, 32'h0000_000A);
      rchk("cmd", afs_pkg::ADDR_CMD, 32'h0000_0000);
      // supply still absent at power-up
      settle;
      jchk(1);
      q(2'd0, 32'h0000_0001);
      volts_req <= 8'h30;
      settle;
      cmd(afs_pkg::CMD_ENABLE);
      en_chk("enable after supply", 1'b1);
      volts_req <= 8'h11;
      en_chk("undervoltage off", 1'b0);
      volts_req <= 8'h12;
      en_chk("undervoltage self clear", 1'b1);
      jchk(1);
      $display("test undervoltage finished");
      volts_req <= 8'h5E;
      settle;
      chk("at ov trip level", 1, amp_enable);
      volts_req <= 8'h5F;
      en_chk("overvoltage off", 1'b0);
      q(2'd0, 32'h0000_0001 << afs_pkg::ST_OV);
      volts_req <= 8'h5C;
      settle;
      chk("inside hysteresis", 0, amp_enable);
      volts_req <= 8'h59;
      en_chk("overvoltage self clear", 1'b1);
      jchk(0);
      $display("test overvoltage finished");
      amps_req <= 8'h14;
      settle;
      chk("at oc trip level", 1, amp_enable);
      q(2'd2, 32'h0000_0001);
      amps_req <= 8'h15;
      en_chk("overcurrent off", 1'b0);
      q(2'd0, 32'h0000_0001 << afs_pkg::ST_OC);
      jchk(1);
      cmd(afs_pkg::CMD_ENABLE);
      settle;
      chk("enable during oc", 0, amp_enable);
      amps_req <= 8'h00;
      settle;
      chk("oc latched", 0, amp_enable);
      q(2'd2, 32'h0000_0000);
      cmd(afs_pkg::CMD_ENABLE);
      en_chk("oc recovered", 1'b1);
      $display("test overcurrent finished");
      deg_req <= 8'h51;
      en_chk("overtemp off", 1'b0);
      q(2'd0, 32'h0000_0001 << afs_pkg::ST_OT);
      jchk(1);
      deg_req <= 8'h4F;
      settle;
      chk("ot latched", 0, amp_enable);
      cmd(afs_pkg::CMD_ENABLE);
      en_chk("ot recovered", 1'b1);
      $display("test overtemperature finished");
      lock_req <= 1'b1;
      en_chk("lockout off", 1'b0);
      chk("lockout motor off", 1, motor_off);
      q(2'd3, {24'h00_0000, afs_pkg::LOCK_ANSWER});
      jchk(1);
      lock_req <= 1'b0;
      cmd(afs_pkg::CMD_ENABLE);
      settle;
      chk("enable alone after lockout", 0, amp_enable);
      cmd(afs_pkg::CMD_MOTOR_OFF);
      cmd(afs_pkg::CMD_ENABLE);
      en_chk("lockout recovered", 1'b1);
      $display("test lockout finished");
      wr(afs_pkg::ADDR_HOLD, 32'h0000_0005);
      short_req <= 1'b1;
      en_chk("short off", 1'b0);
      q(2'd0, 32'h0000_0001);
      short_req <= 1'b0;
      cmd(afs_pkg::CMD_MOTOR_OFF);
      cmd(afs_pkg::CMD_ENABLE);
      settle;
      chk("short needs hold zero", 0, amp_enable);
      wr(afs_pkg::ADDR_HOLD, 32'h0000_0000);
      cmd(afs_pkg::CMD_MOTOR_OFF);
      cmd(afs_pkg::CMD_ENABLE);
      en_chk("short recovered", 1'b1);
      $display("test drive short finished");
      wr(afs_pkg::ADDR_CTRL, 32'h0000_0002);
      rchk("ctrl servo", afs_pkg::ADDR_CTRL, 32'h0000_0002);
      chk("servo pulses", 0, step_active_high);
      wr(afs_pkg::ADDR_CTRL, 32'h0000_0003);
      rchk("ctrl bad code", afs_pkg::ADDR_CTRL, 32'h0000_0002);
      wr(afs_pkg::ADDR_CTRL, 32'h0000_0001);
      rchk("ctrl half", afs_pkg::ADDR_CTRL, 32'h0000_0001);
      chk("stepper pulses", 1, step_active_high);
      foreach (res_codes[i]) begin
         wr(afs_pkg::ADDR_STEP, (res_codes[i] << 8) | 32'h0000_0040);
         rchk("step code", afs_pkg::ADDR_STEP, (res_codes[i] << 8) | 32'h0000_0040);
      end
      wr(afs_pkg::ADDR_STEP, 32'h0000_0340);
      rchk("step bad code", afs_pkg::ADDR_STEP, 32'h0000_1040);
      apb(1'b0, 8'h40, 32'h0000_0000);
      chk("unmapped error", 1, err);
      chk("unmapped data", 0, rd);
      $display("test registers finished");
      wr(afs_pkg::ADDR_STEP, 32'h0000_0240);
      rest_req <= 1'b1;
      settle;
      chk("hold mode 0", 100, hold_pct);
      wr(afs_pkg::ADDR_HOLD, 32'h0000_0001);
      settle;
      chk("hold mode 1", 25, hold_pct);
      wr(afs_pkg::ADDR_HOLD, 32'h0000_0003);
      rest_req <= 1'b0;
      settle;
      chk("moving", 100, hold_pct);
      rest_req <= 1'b1;
      repeat (12) @(posedge pclk);
      chk("hold delay running", 100, hold_pct);
      settle;
      chk("hold delay expired", 25, hold_pct);
      wr(afs_pkg::ADDR_HOLD, 32'h0000_0000);
      wr(afs_pkg::ADDR_STEP, 32'h0000_0140);
      settle;
      chk("full step hold", 70, hold_pct);
      cmd(afs_pkg::CMD_RESET);
      rchk("ctrl after reset", afs_pkg::ADDR_CTRL, 32'h0000_0000);
      $display("test hold current finished");
      print_verdict;
   end
endmodule : afs_supervisor_bench
